// File: core/flash_host_pkg.sv
/*
 Constants, types and helpers for the host-side controller of a
 block-erasable parallel flash memory. Assumes a 10 MHz design clock
 and a 16-bit organised part with a 256K-word address space.
*/
// Operation
// - Erase is 20h then D0h at block
// - First-cycle address held stable whole cycle
// - Boot block needs unlock plus high supply
// - Hold reset low during power ramp
// - Program is 40h or 10h then data
package flash_host_pkg;

	// Clock and pin timing, in ns and in cycles
	localparam int CLK_NS    = 100;
	localparam int T_RP_NS   = 150;  // Least reset low pulse
	localparam int T_RWH_NS  = 1000; // Reset high to first access
	localparam int T_ACC_NS  = 80;   // Read access time
	localparam int T_WP_NS   = 100;  // Write strobe low time
	localparam int SYNC_CYC  = 2;    // Input synchroniser depth
	localparam int RP_CYC    = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RWH_CYC   = (T_RWH_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC    = ACC_CYC + SYNC_CYC + 1;

	// Widths and address fields
	localparam int ADDR_W    = 18;
	localparam int DATA_W    = 16;
	localparam int BLOCK_LSB = 12;

	// Command codes
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_IDENTIFY   = 8'h90;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_CLEAR      = 8'h50;
	localparam logic [7:0] CMD_ERASE      = 8'h20;
	localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
	localparam logic [7:0] CMD_PROGRAM    = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT   = 8'h10;
	localparam logic [7:0] CMD_SUSPEND    = 8'hb0;

	// Status byte bit positions
	localparam int SB_READY   = 7;
	localparam int SB_SUSPEND = 6;
	localparam int SB_ERASE   = 5;
	localparam int SB_PROGRAM = 4;
	localparam int SB_SUPPLY  = 3;

	// User operations
	typedef enum logic [3:0] {
		OP_READ, OP_IDENT, OP_STATUS, OP_CLEAR, OP_PROGRAM,
		OP_ERASE, OP_SUSPEND, OP_RESUME, OP_RESET
	} op_t;

	// Outcome codes
	typedef enum logic [2:0] {
		E_NONE, E_SUPPLY, E_PROGRAM, E_ERASE, E_SEQUENCE, E_REFUSED, E_TIMEOUT
	} err_t;

	typedef struct packed {
		op_t                op;
		logic               alt_code; // Use the alternate program code
		logic               no_poll;  // Program or erase returns right after the command
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  data;
	} req_t;

	typedef struct packed {
		logic [DATA_W-1:0]  data;
		logic [7:0]         status;
		err_t               err;
	} resp_t;

	// Error flag decode of a status byte
	function automatic err_t err_decode(input logic [7:0] s);
		if (s[SB_ERASE] && s[SB_PROGRAM])
			return E_SEQUENCE;
		else if (s[SB_SUPPLY])
			return E_SUPPLY;
		else if (s[SB_ERASE])
			return E_ERASE;
		else if (s[SB_PROGRAM])
			return E_PROGRAM;
		return E_NONE;
	endfunction

endpackage

// File: core/flash_host_ctrl.sv
/*
 Host-side controller that runs flash command sequences over the
 part's strobe pins. Assumes the data pins are resolved outside from
 dq_out and dq_oe, and that the part follows its own command rules.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl #(
	parameter int POLL_MAX = 100000 // Status polls before giving up
) (
	// Clock and reset
	input  wire logic                             mclk,
	input  wire logic                             resetn,
	// User request
	input  wire logic                             req_valid,
	output logic                                  req_ready,
	input  wire flash_host_pkg::req_t             req,
	input  wire logic                             boot_unlock,
	// User answer
	output logic                                  resp_valid,
	output flash_host_pkg::resp_t                 resp,
	output logic                                  supply_blocked,
	// Flash pins
	output logic                                  ce_n,
	output logic                                  we_n,
	output logic                                  oe_n,
	output logic                                  reset_powerdown_n,
	output logic                                  write_protect,
	output logic                                  program_supply_high,
	output logic [flash_host_pkg::ADDR_W-1:0]     addr,
	output logic [flash_host_pkg::DATA_W-1:0]     dq_out,
	output logic                                  dq_oe,
	input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in
);
	import flash_host_pkg::*;

	typedef enum logic [7:0] {
		S_RST   = 8'h01, // Reset pin low
		S_RWAIT = 8'h02, // Recovery after reset release
		S_IDLE  = 8'h04, // Waiting for a request
		S_GAP   = 8'h08, // Strobes high, pick next bus cycle
		S_WADDR = 8'h10, // Address and data set up
		S_WLOW  = 8'h20, // Write strobe low
		S_WHIGH = 8'h40, // Write strobe high, data held
		S_RLOW  = 8'h80  // Chip and output enable low
	} state_t;

	state_t             state_r, state_nxt;     // Sequencer state
	logic [7:0]         cnt_r, cnt_nxt;         // Phase timer
	logic [1:0]         step_r, step_nxt;       // Bus cycle index
	logic [19:0]        polls_r, polls_nxt;     // Poll counter
	req_t               cur_r, cur_nxt;         // Request in progress
	logic               unlock_r, unlock_nxt;   // Boot unlock latched
	logic               vblock_r, vblock_nxt;   // Supply flag seen
	logic [DATA_W-1:0]  rdata_r, rdata_nxt;     // Last read word
	logic [ADDR_W-1:0]  addr_r, addr_nxt;       // Address pins
	logic [DATA_W-1:0]  dq_r, dq_nxt;           // Data pins
	logic               rvalid_r, rvalid_nxt;   // Answer pulse
	resp_t              resp_r, resp_nxt;       // Answer word
	logic               ce_n_r, we_n_r, oe_n_r, rp_n_r, dq_oe_r, vpp_r, wp_r;
	logic [DATA_W-1:0]  dq_s1_r, dq_s2_r;       // Data pin synchroniser
	logic               polled;                 // Op waits for ready
	logic               is_write_op;            // Program or erase

	assign polled      = (cur_r.op == OP_SUSPEND) ||
		((cur_r.op == OP_PROGRAM || cur_r.op == OP_ERASE) && !cur_r.no_poll);
	assign is_write_op = (cur_r.op == OP_PROGRAM) || (cur_r.op == OP_ERASE);

	// Sequencer next state
	always_comb
	begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		step_nxt   = step_r;
		polls_nxt  = polls_r;
		cur_nxt    = cur_r;
		unlock_nxt = unlock_r;
		vblock_nxt = vblock_r;
		rdata_nxt  = rdata_r;
		addr_nxt   = addr_r;
		dq_nxt     = dq_r;
		rvalid_nxt = 1'b0;
		resp_nxt   = resp_r;
		unique case (state_r)
			S_RST:
			begin
				// Reset low long enough, then recovery
				if (cnt_r == 8'h00)
				begin
					state_nxt  = S_RWAIT;
					cnt_nxt    = 8'(RWH_CYC - 1);
					vblock_nxt = 1'b0;
				end
				else
					cnt_nxt = cnt_r - 8'h01;
			end
			S_RWAIT:
			begin
				if (cnt_r == 8'h00)
					state_nxt = S_IDLE;
				else
					cnt_nxt = cnt_r - 8'h01;
			end
			S_IDLE:
			begin
				if (req_valid)
				begin
					cur_nxt    = req;
					unlock_nxt = boot_unlock;
					step_nxt   = 2'd0;
					polls_nxt  = '0;
					if (req.op == OP_RESET)
					begin
						state_nxt = S_RST;
						cnt_nxt   = 8'(RP_CYC - 1);
					end
					else if ((req.op == OP_PROGRAM || req.op == OP_ERASE) && vblock_r)
					begin
						// Part would ignore it anyway; say so at once
						rvalid_nxt    = 1'b1;
						resp_nxt.err  = E_REFUSED;
						resp_nxt.data = '0;
						resp_nxt.status = '0;
					end
					else
					begin
						state_nxt = S_GAP;
						addr_nxt  = req.addr;
					end
				end
			end
			S_GAP:
			begin
				unique case (step_r)
					2'd0:
					begin
						// First cycle: command code, address kept stable
						state_nxt = S_WADDR;
						step_nxt  = 2'd1;
						unique case (cur_r.op)
							OP_READ:    dq_nxt = {8'h00, CMD_READ_ARRAY};
							OP_IDENT:   dq_nxt = {8'h00, CMD_IDENTIFY};
							OP_STATUS:  dq_nxt = {8'h00, CMD_STATUS};
							OP_CLEAR:   dq_nxt = {8'h00, CMD_CLEAR};
							OP_ERASE:   dq_nxt = {8'h00, CMD_ERASE};
							OP_SUSPEND: dq_nxt = {8'h00, CMD_SUSPEND};
							OP_RESUME:  dq_nxt = {8'h00, CMD_CONFIRM};
							default:    dq_nxt = {8'h00, cur_r.alt_code ? CMD_PROG_ALT
								: CMD_PROGRAM};
						endcase
					end
					2'd1:
					begin
						if (cur_r.op == OP_PROGRAM)
						begin
							state_nxt = S_WADDR;
							dq_nxt    = cur_r.data;
							step_nxt  = 2'd2;
						end
						else if (cur_r.op == OP_ERASE)
						begin
							// Block picked by the upper word address bits
							state_nxt = S_WADDR;
							addr_nxt  = {cur_r.addr[ADDR_W-1:BLOCK_LSB],
								BLOCK_LSB'(0)};
							dq_nxt    = {8'h00, CMD_CONFIRM};
							step_nxt  = 2'd2;
						end
						else if (cur_r.op == OP_CLEAR || cur_r.op == OP_RESUME)
						begin
							state_nxt     = S_IDLE;
							rvalid_nxt    = 1'b1;
							resp_nxt.data = '0;
							resp_nxt.status = '0;
							resp_nxt.err  = E_NONE;
							if (cur_r.op == OP_CLEAR)
								vblock_nxt = 1'b0;
						end
						else
						begin
							state_nxt = S_RLOW;
							cnt_nxt   = 8'(RD_CYC - 1);
							step_nxt  = 2'd3;
						end
					end
					2'd2:
					begin
						if (cur_r.no_poll)
						begin
							state_nxt     = S_IDLE;
							rvalid_nxt    = 1'b1;
							resp_nxt.data = '0;
							resp_nxt.status = '0;
							resp_nxt.err  = E_NONE;
						end
						else
						begin
							// Part now answers every read with status
							state_nxt = S_RLOW;
							cnt_nxt   = 8'(RD_CYC - 1);
							step_nxt  = 2'd3;
						end
					end
					default:
					begin
						if (polled && !rdata_r[SB_READY] && polls_r != 20'(POLL_MAX - 1))
						begin
							// Strobes went high in between, so status refreshes
							state_nxt = S_RLOW;
							cnt_nxt   = 8'(RD_CYC - 1);
							polls_nxt = polls_r + 20'h00001;
						end
						else
						begin
							state_nxt       = S_IDLE;
							rvalid_nxt      = 1'b1;
							resp_nxt.data   = rdata_r;
							resp_nxt.status = {rdata_r[7:3], 3'h0};
							if (polled && !rdata_r[SB_READY])
								resp_nxt.err = E_TIMEOUT;
							else if (polled)
								resp_nxt.err = err_decode(rdata_r[7:0]);
							else
								resp_nxt.err = E_NONE;
							if (polled && rdata_r[SB_SUPPLY])
								vblock_nxt = 1'b1;
						end
					end
				endcase
			end
			S_WADDR:
			begin
				state_nxt = S_WLOW;
				cnt_nxt   = 8'(WP_CYC - 1);
			end
			S_WLOW:
			begin
				// Part latches on the strobe's rising edge
				if (cnt_r == 8'h00)
					state_nxt = S_WHIGH;
				else
					cnt_nxt = cnt_r - 8'h01;
			end
			S_WHIGH:
				state_nxt = S_GAP;
			S_RLOW:
			begin
				if (cnt_r == 8'h00)
				begin
					state_nxt = S_GAP;
					rdata_nxt = dq_s2_r;
				end
				else
					cnt_nxt = cnt_r - 8'h01;
			end
			default:
				state_nxt = S_RST;
		endcase
	end

	// Sequencer registers; pins follow the next state
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r  <= S_RST;
			cnt_r    <= 8'(RP_CYC - 1);
			step_r   <= 2'd0;
			polls_r  <= '0;
			cur_r    <= '0;
			unlock_r <= 1'b0;
			vblock_r <= 1'b0;
			rdata_r  <= '0;
			addr_r   <= '0;
			dq_r     <= '0;
			rvalid_r <= 1'b0;
			resp_r   <= '0;
			ce_n_r   <= 1'b1;
			we_n_r   <= 1'b1;
			oe_n_r   <= 1'b1;
			rp_n_r   <= 1'b0;
			dq_oe_r  <= 1'b0;
			vpp_r    <= 1'b0;
			wp_r     <= 1'b0;
			dq_s1_r  <= '0;
			dq_s2_r  <= '0;
		end
		else
		begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			step_r   <= step_nxt;
			polls_r  <= polls_nxt;
			cur_r    <= cur_nxt;
			unlock_r <= unlock_nxt;
			vblock_r <= vblock_nxt;
			rdata_r  <= rdata_nxt;
			addr_r   <= addr_nxt;
			dq_r     <= dq_nxt;
			rvalid_r <= rvalid_nxt;
			resp_r   <= resp_nxt;
			ce_n_r   <= !(state_nxt inside {S_WADDR, S_WLOW, S_WHIGH, S_RLOW});
			we_n_r   <= state_nxt != S_WLOW;
			oe_n_r   <= state_nxt != S_RLOW;
			rp_n_r   <= state_nxt != S_RST;
			dq_oe_r  <= state_nxt inside {S_WADDR, S_WLOW, S_WHIGH};
			// Supply kept high until the sequencer returns to idle
			vpp_r    <= (cur_nxt.op == OP_PROGRAM || cur_nxt.op == OP_ERASE)
				&& (state_nxt inside {S_GAP, S_WADDR, S_WLOW, S_WHIGH, S_RLOW});
			wp_r     <= unlock_nxt && (cur_nxt.op == OP_PROGRAM || cur_nxt.op == OP_ERASE)
				&& (state_nxt inside {S_GAP, S_WADDR, S_WLOW, S_WHIGH, S_RLOW});
			dq_s1_r  <= dq_in;
			dq_s2_r  <= dq_s1_r;
		end
	end

	assign req_ready           = state_r == S_IDLE;
	assign resp_valid          = rvalid_r;
	assign resp                = resp_r;
	assign supply_blocked      = vblock_r;
	assign ce_n                = ce_n_r;
	assign we_n                = we_n_r;
	assign oe_n                = oe_n_r;
	assign reset_powerdown_n   = rp_n_r;
	assign write_protect       = wp_r;
	assign program_supply_high = vpp_r;
	assign addr                = addr_r;
	assign dq_out              = dq_r;
	assign dq_oe               = dq_oe_r;

	// Checks
	property p_rst_width;
		@(posedge mclk) disable iff (!resetn) $fell(rp_n_r) |-> !rp_n_r[*2];
	endproperty
	a_rst_width: assert property (p_rst_width) else $error("reset pulse short");

	property p_rst_recover;
		@(posedge mclk) disable iff (!resetn) $rose(rp_n_r) |-> !req_ready[*8];
	endproperty
	a_rst_recover: assert property (p_rst_recover) else $error("access too soon");

	property p_we_in_ce;
		@(posedge mclk) disable iff (!resetn) !we_n_r |-> !ce_n_r && oe_n_r && dq_oe_r;
	endproperty
	a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe outside cycle");

	property p_addr_stable;
		@(posedge mclk) disable iff (!resetn) (!ce_n_r && !$past(ce_n_r)) |-> $stable(addr_r);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved");

	property p_confirm_supply;
		@(posedge mclk) disable iff (!resetn)
			(!we_n_r && step_r == 2'd2 && is_write_op) |-> vpp_r;
	endproperty
	a_confirm_supply: assert property (p_confirm_supply) else $error("no supply");

	property p_erase_block;
		@(posedge mclk) disable iff (!resetn) (!we_n_r && cur_r.op == OP_ERASE
			&& step_r == 2'd2) |-> addr_r[BLOCK_LSB-1:0] == '0 && dq_r[7:0] == CMD_CONFIRM;
	endproperty
	a_erase_block: assert property (p_erase_block) else $error("bad confirm");

	property p_refuse;
		@(posedge mclk) disable iff (!resetn) (req_valid && req_ready && vblock_r
			&& (req.op == OP_PROGRAM || req.op == OP_ERASE))
			|=> resp_valid && resp.err == E_REFUSED && req_ready && ce_n_r;
	endproperty
	a_refuse: assert property (p_refuse) else $error("blocked op issued");

	property p_poll_toggle;
		@(posedge mclk) disable iff (!resetn) $fell(oe_n_r) |-> $past(ce_n_r);
	endproperty
	a_poll_toggle: assert property (p_poll_toggle) else $error("no strobe toggle");

	c_erase: cover property (@(posedge mclk) disable iff (!resetn)
		resp_valid && cur_r.op == OP_ERASE && resp.err == E_NONE);
	c_suspend: cover property (@(posedge mclk) disable iff (!resetn)
		resp_valid && cur_r.op == OP_SUSPEND && resp.status[SB_SUSPEND]);
	c_refuse: cover property (@(posedge mclk) disable iff (!resetn)
		resp_valid && resp.err == E_REFUSED);
endmodule
`default_nettype wire

// File: core/placeholder_none.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: tb/flash_part_model.sv
/*
 Behavioural model of the flash part seen by the host controller.
 Assumes the bench resolves the data pins and lends mclk for timing.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_part_model #(
	parameter int          PROG_CYC  = 8,       // Embedded program time
	parameter int          ERASE_CYC = 60,      // Embedded erase time
	parameter logic [15:0] MFR_ID    = 16'h00a5, // Arbitrary value
	parameter logic [15:0] DEV_ID    = 16'h005c  // Arbitrary value
) (
	// Timing clock
	input  wire logic        mclk,
	// Part pins
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        reset_powerdown_n,
	input  wire logic        write_protect,
	input  wire logic        program_supply_high,
	input  wire logic [17:0] addr,
	input  wire logic [15:0] dq_wr,
	output logic      [15:0] dq_o,
	// Fault injection
	input  wire logic        supply_fail
);
	logic [15:0] mem [int];  // Written words; absent means erased
	logic [7:3]  stat;       // Ready, suspend, erase, program, supply
	logic [1:0]  mode;       // Array, identify or status read
	logic [1:0]  pend;       // Second cycle owed: erase 1, program 2
	logic        busy;
	logic        susp_req;
	logic        is_erase;
	logic [17:0] op_a;
	logic [15:0] op_d;
	logic [15:0] snap;       // Word frozen while strobes stay low
	logic [7:0]  c;
	int          cnt;
	int          ks[$];
	function automatic logic [15:0] rd(input logic [17:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction
	// Command latch on the write strobe's rising edge
	always @(posedge we_n)
		if (ce_n === 1'b0 && reset_powerdown_n === 1'b1)
		begin
			c = dq_wr[7:0];
			if (busy && !stat[6])
				susp_req = c == 8'hb0 || (susp_req && c != 8'hd0);
			else if (pend == 1 && c != 8'hd0)
				{stat[5:4], mode, pend} = 6'b111000;
			else if (pend != 0 && (stat[3] || !program_supply_high || supply_fail))
				{stat[3], mode, pend} = 5'b11000;
			else if (pend != 0 && addr[17:12] == 6'h00 && !write_protect)
				{stat[4 + pend[0]], mode, pend} = 5'b11000;
			else if (pend != 0)
			begin
				{busy, stat[7], mode} = 4'b1010;
				cnt = pend[0] ? ERASE_CYC : PROG_CYC;
				{is_erase, op_a, op_d, pend} = {pend[0], addr, dq_wr, 2'b00};
			end
			// Suspended part takes only three commands
			else if (stat[6] && c != 8'hff && c != 8'h70 && c != 8'hd0)
				c = 8'h00;
			else
				case (c)
					8'hff: mode = 0;
					8'h90: mode = 1;
					8'h70: mode = 2;
					8'h50: stat[5:3] = 3'b000;
					8'h20: pend = 1;
					8'h40, 8'h10: pend = 2;
					8'hd0: if (stat[6]) {stat[7:6], mode} = 4'b0010;
					default: ;
				endcase
		end
	// Embedded machine; keeps running with the chip deselected
	always @(posedge mclk or negedge reset_powerdown_n)
		if (!reset_powerdown_n)
			{stat, mode, pend, busy, susp_req} = 11'h400;
		else if (busy && susp_req)
			{stat[7:6], susp_req} = 3'b110;
		else if (busy && !stat[6] && cnt > 1)
			cnt--;
		else if (busy && !stat[6])
		begin
			foreach (mem[k])
				if (is_erase && k[17:12] == op_a[17:12])
					ks.push_back(k);
			foreach (ks[i])
				mem.delete(ks[i]);
			ks.delete();
			if (!is_erase)
				mem[op_a] = rd(op_a) & op_d;
			{busy, stat[7]} = 2'b01;
		end
	// Output word picked at the strobes' fall, then held
	always @(negedge oe_n or negedge ce_n)
		snap = ((busy && !stat[6]) || mode == 2) ? {8'h00, stat, 3'b000}
			: (mode == 1 ? (addr[0] ? DEV_ID : MFR_ID) : rd(addr));
	// Released bus shows the inverse so a stale word cannot pass
	assign dq_o = (!ce_n && !oe_n) ? snap : ~snap;
endmodule
`default_nettype wire

// File: tb/test_flash_host_ctrl.sv
/*
 Self-checking bench: host controller driving the flash part model.
 Assumes the controller's request and answer contract.
*/
`timescale 1ns/1ns
`default_nettype none
module test_flash_host_ctrl;
	import flash_host_pkg::*;
	localparam logic [15:0] MFR = 16'h00a5; // Arbitrary value
	localparam logic [15:0] DEV = 16'h005c; // Arbitrary value
	logic        mclk, resetn, req_valid, req_ready, boot_unlock, resp_valid;
	logic        supply_blocked, supply_fail, ce_n, we_n, oe_n, pd_n, prot, supply_on;
	logic        dq_oe;
	req_t        req;
	resp_t       resp;
	logic [17:0] addr;
	logic [15:0] dq_out, dq_in, dq_part;
	int          errors = 0, n_tests = 0, cyc = 0;
	logic [17:0] pa [3] = '{18'h01234, 18'h02345, 18'h03456};
	logic [15:0] pd [3] = '{16'h1234, 16'hbeef, 16'h5a5a};
	flash_host_ctrl #(.POLL_MAX(20)) dut_u (.mclk(mclk), .resetn(resetn),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .boot_unlock(boot_unlock),
		.resp_valid(resp_valid), .resp(resp), .supply_blocked(supply_blocked), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .reset_powerdown_n(pd_n), .write_protect(prot),
		.program_supply_high(supply_on), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in));
	flash_part_model #(.MFR_ID(MFR), .DEV_ID(DEV)) part_u (.mclk(mclk), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .reset_powerdown_n(pd_n), .write_protect(prot),
		.program_supply_high(supply_on), .addr(addr), .dq_wr(dq_out), .dq_o(dq_part),
		.supply_fail(supply_fail));
	// Controller wins the data pins while it drives them
	assign dq_in = dq_oe ? dq_out : dq_part;
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Hang guard, well past the longest sequence
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			summarize();
		end
	end
	task automatic summarize();
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One request; holds it until taken, then waits for the answer
	task automatic run(input op_t op, input logic [17:0] a, input logic [15:0] d = 16'h0000,
		input logic alt = 1'b0, input logic np = 1'b0, input logic ul = 1'b0);
		int k;
		@(negedge mclk);
		req = '{op, alt, np, a, d};
		boot_unlock = ul;
		req_valid = 1'b1;
		for (k = 0; k < 300 && req_ready !== 1'b1; k++)
			@(negedge mclk);
		if (k == 300)
			errors++;
		@(negedge mclk);
		req_valid = 1'b0;
		// Reset request has no answer pulse; wait for idle instead
		for (k = 0; k < 900 && (op == OP_RESET ? req_ready : resp_valid) !== 1'b1; k++)
			@(negedge mclk);
		if (k == 900)
			errors++;
	endtask
	initial
	begin
		{resetn, req_valid, boot_unlock, supply_fail} = 4'b0000;
		req = '0;
		repeat (16) @(negedge mclk);
		resetn = 1'b1;
		run(OP_READ, 18'h00010);
		chk("blank", 16'hffff, resp.data);
		for (int i = 0; i < 2; i++)
		begin
			run(OP_IDENT, 18'(i));
			chk("ident", i ? DEV : MFR, resp.data);
		end
		foreach (pa[i])
		begin
			run(OP_PROGRAM, pa[i], pd[i], i[0]);
			chk("prog", 16'(E_NONE), 16'(resp.err));
			run(OP_READ, pa[i]);
			chk("readback", pd[i], resp.data);
		end
		run(OP_STATUS, 18'h3ffff);
		chk("idle", 16'h0080, {8'h00, resp.status});
		run(OP_ERASE, 18'h01fff);
		chk("erase", 16'(E_NONE), 16'(resp.err));
		run(OP_READ, pa[0]);
		chk("erased", 16'hffff, resp.data);
		run(OP_READ, pa[1]);
		chk("kept", pd[1], resp.data);
		// Background erase of block 2, paused and resumed
		run(OP_ERASE, pa[1], 16'h0000, 1'b0, 1'b1);
		run(OP_SUSPEND, 18'h0);
		chk("suspended", 16'h00c0, {8'h00, resp.status});
		run(OP_READ, pa[2]);
		chk("other block", pd[2], resp.data);
		run(OP_RESUME, 18'h0);
		run(OP_STATUS, 18'h0);
		chk("resumed", 16'h0000, {8'h00, resp.status});
		for (int k = 0; k < 20 && resp.status !== 8'h80; k++)
			run(OP_STATUS, 18'h0);
		chk("erase done", 16'h0080, {8'h00, resp.status});
		run(OP_READ, pa[1]);
		chk("block 2 erased", 16'hffff, resp.data);
		// Boot block: locked, then reset, then unlocked
		run(OP_ERASE, 18'h00100);
		chk("boot locked", 16'(E_ERASE), 16'(resp.err));
		run(OP_STATUS, 18'h0);
		chk("flag kept", 16'h00a0, {8'h00, resp.status});
		run(OP_RESET, 18'h0);
		run(OP_STATUS, 18'h0);
		chk("after reset", 16'h0080, {8'h00, resp.status});
		run(OP_ERASE, 18'h00100, 16'h0000, 1'b0, 1'b0, 1'b1);
		chk("boot unlocked", 16'(E_NONE), 16'(resp.err));
		// Missing supply blocks writes until cleared
		supply_fail = 1'b1;
		run(OP_PROGRAM, 18'h03000, 16'h0f0f);
		chk("no supply", 16'(E_SUPPLY), 16'(resp.err));
		chk("blocked", 16'h0001, 16'(supply_blocked));
		supply_fail = 1'b0;
		run(OP_PROGRAM, 18'h03000, 16'h0f0f);
		chk("refused", 16'(E_REFUSED), 16'(resp.err));
		run(OP_STATUS, 18'h0);
		chk("supply kept", 16'h0088, {8'h00, resp.status});
		run(OP_CLEAR, 18'h0);
		run(OP_STATUS, 18'h0);
		chk("cleared", 16'h0080, {8'h00, resp.status});
		run(OP_PROGRAM, 18'h03000, 16'h0f0f);
		chk("prog again", 16'(E_NONE), 16'(resp.err));
		summarize();
	end
endmodule
`default_nettype wire
